// ==== logic/amp_fault_pkg.sv ====
// package: register map, field positions and carrier types of the fault report block
package amp_fault_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_GLOBAL_THERMAL = 8'h72;
  localparam logic [7:0] IDX_TEMP_WARNING   = 8'h73;
  localparam logic [7:0] IDX_REPORT_MASK    = 8'h74;
  localparam logic [7:0] IDX_LATCH_CONTROL  = 8'h75;
  localparam logic [7:0] IDX_MISC_CONTROL   = 8'h76;
  localparam logic [7:0] IDX_FAULT_CLEAR    = 8'h78;
  localparam logic [7:0] IDX_CHAN_FAULT     = 8'h70;
  localparam logic [7:0] IDX_GLOBAL_SUPPLY  = 8'h71;
  localparam logic [7:0] IDX_IRQ_STATUS     = 8'h7c;
  localparam logic [7:0] IDX_IRQ_MASK       = 8'h7d;
  // reset values
  localparam logic [7:0] RST_REPORT_MASK    = 8'h00;
  localparam logic [7:0] RST_LATCH_CONTROL  = 8'hf8;
  localparam logic [7:0] RST_MISC_CONTROL   = 8'h00;
  localparam logic [7:0] RST_IRQ_MASK       = 8'h00;
  // report mask bits
  localparam int MSK_SHUTDOWN    = 7;
  localparam int MSK_CORE_LOW    = 6;
  localparam int MSK_CORE_HIGH   = 5;
  localparam int MSK_CLOCK       = 4;
  localparam int MSK_POWER_LOW   = 3;
  localparam int MSK_POWER_HIGH  = 2;
  localparam int MSK_DC          = 1;
  localparam int MSK_OC          = 0;
  // latch control bits
  localparam int LAT_CLOCK       = 5;
  localparam int LAT_SHUTDOWN    = 4;
  localparam int LAT_WARNING     = 3;
  localparam int LAT_WARN_MASK   = 2;
  localparam logic [7:0] LAT_WRITABLE = 8'hfc;
  // misc control bits
  localparam int MISC_CLK_HOLD   = 7;
  localparam int MISC_AUTO_REC   = 4;
  // status bit positions
  localparam int POS_SHUTDOWN    = 0;
  localparam int POS_WARNING     = 2;
  localparam int POS_CLEAR       = 7;
  localparam int POS_CLK_FAULT   = 2;
  localparam int POS_PVDD_OV     = 1;
  localparam int POS_PVDD_UV     = 0;
  // interrupt status bit positions
  localparam int IRQ_SHUTDOWN    = 0;
  localparam int IRQ_WARNING     = 1;
  localparam int IRQ_CLOCK       = 2;
  localparam int IRQ_SUPPLY      = 3;
  localparam int IRQ_CHANNEL     = 4;
  localparam int IRQ_BITS        = 5;

  // raw fault detector levels from the analog side
  typedef struct packed {
    logic       shutdown;   // die temperature at shutdown point
    logic       warning;    // die temperature at 135 C warning point
    logic       clock;      // clock detector fault
    logic       core_low;
    logic       core_high;
    logic       power_low;
    logic       power_high;
    logic [1:0] dc;         // [1] left, [0] right
    logic [1:0] oc;         // [1] left, [0] right
  } fault_in_t;

  // apb request carried as one group
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
endpackage : amp_fault_pkg

// ==== logic/amp_fault_report_regs.sv ====
// fault status, report mask, latch, recovery and clear registers behind an apb slave
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
module amp_fault_report_regs (
  input  wire logic                    core_clk,
  input  wire logic                    rstn,
  input  wire amp_fault_pkg::apb_req_t apb_req,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  input  wire amp_fault_pkg::fault_in_t fault_in,
  output logic                         fault_report,
  output logic                         shutdown_active,
  output logic                         irq
);

  typedef struct packed {
    logic [7:0]                  report_mask_r;
    logic [7:0]                  latch_control_r;
    logic [7:0]                  misc_control_r;
    logic                        shutdown_r;
    logic                        warning_r;
    logic                        clock_r;
    logic                        clk_detect_r;
    logic [1:0]                  dc_r;
    logic [1:0]                  oc_r;
    logic                        power_low_r;
    logic                        power_high_r;
    logic                        off_r;
    logic [amp_fault_pkg::IRQ_BITS-1:0] irq_status_r;
    logic [amp_fault_pkg::IRQ_BITS-1:0] irq_mask_r;
    logic [31:0]                 prdata_r;
    logic                        slverr_r;
    logic                        report_r;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // how the block behaves, for whoever maintains it next
  //
  // bus side
  // - the slave never stalls: pready is a constant one
  // - a write lands at the edge that closes the access cycle
  // - read data is registered at that same edge
  // - so prdata is valid in the cycle after the access
  // - this lag trades strict bus timing for a flopped output
  // - a master that samples prdata at the access edge sees old data
  // - only the low byte of each word carries a register
  // - the upper 24 bits of read data are always zero
  // - a misaligned or unknown address answers with pslverr
  // - pslverr stands for one cycle only, after the access
  // - a refused write changes nothing at all
  // - a refused read returns zero in the low byte
  // - prdata keeps its last value until the next read
  //
  // register map, by word index
  // - 0x70 channel faults: dc left/right, oc left/right
  // - 0x71 supply faults: clock, power high, power low
  // - 0x72 thermal shutdown status, bit 0 only
  // - 0x73 thermal warning status, bit 2 only
  // - 0x74 report mask, one bit per fault kind
  // - 0x75 latch control, plus the warning report mask
  // - 0x76 misc control: clock detect hold, auto recovery
  // - 0x78 fault clear command, write only
  // - 0x7c interrupt status, write one to clear
  // - 0x7d interrupt mask
  //
  // status bits
  // - a latched bit is set by its cause and held afterwards
  // - an unlatched bit simply follows its cause
  // - the clear command drops held bits at the next edge; they stay low until a cause returns
  // - a cause still present at the clear sets the bit again
  // - so a clear can never hide a live fault
  // - power high and power low faults are never held; they are live levels
  // - channel dc and oc faults are always held until clear
  // - there is no latch enable for the channel faults
  //
  // latch control
  // - bits 5, 4, 3 pick which causes are held
  // - they reset to one, so faults are held by default
  // - bit 2 masks the warning in the external report
  // - bits 7-6 are writable and reset to ones
  // - bits 1-0 are kept at zero whatever is written
  // - turning a latch off does not drop a held bit at once
  // - the held bit falls at the next edge if its cause is gone
  //
  // clock detect hold
  // - with misc bit 7 low, the detect status is live
  // - with it high, the status holds until the clear command
  // - this status is internal; it feeds nothing on the ports
  // - it is kept so that a later read path can reach it
  //
  // power stage off flag
  // - set whenever the shutdown cause is present
  // - with auto recovery on it falls when the die cools
  // - with auto recovery off only the clear command lowers it
  // - a clear while the cause persists leaves it set
  // - auto recovery does not touch the shutdown status bit
  // - software still sees the event in the status register
  //
  // external report
  // - one flopped level, one cycle behind its causes
  // - a fault counts if live or held, unless masked
  // - masks act on the report only, never on a status bit
  // - unmasking a held fault raises the report next cycle
  // - masking a live fault drops the report next cycle
  // - all masks reset to zero, so every fault reports
  //
  // interrupt
  // - five sticky event bits, one per fault group
  // - an event is any cycle in which its cause is present
  // - a level cause sets the bit again every cycle
  // - so a write-one clear only sticks once the cause is gone
  // - the event wins over a clear in the same cycle
  // - irq is the or of status anded with mask, no extra flop
  // - the mask resets to zero, so irq is quiet at start
  //
  // clear command
  // - writing one to bit 7 of the clear word fires it
  // - the command is a one-cycle pulse, never stored
  // - the clear word therefore always reads back zero
  // - writing zero to bit 7 does nothing
  // - the other bits of the clear word are ignored
  //
  // reset
  // - asynchronous, active low, whole state at once
  // - every status bit and flag starts clear
  // - control registers start at their documented values
  // - the first bus access may come at the first edge after
  //
  // inputs
  // - fault causes are levels, already synchronous here
  // - no filtering is done; a one-cycle glitch is a fault
  // - the analog side is trusted to debounce its detectors
  //
  // limitations
  // - no wait states, so a slow read path cannot be added
  // - only one clock; all timing is counted in its cycles
  // - overvoltage and undervoltage of the core supply
  //   reach the report and the interrupt but no status word
  // - byte lanes are not honoured; the whole byte is written
  //
  // structure
  // - the whole state sits in one packed struct
  // - one always_comb builds its next value
  // - one always_ff registers it
  // - this keeps every register on one reset path

  // word index from a byte address; misaligned addresses fall outside the map
  function automatic logic [9:0] word_index(input logic [11:0] addr);
    word_index = addr[11:2];
  endfunction : word_index

  function automatic logic hits(input logic [11:0] addr, input logic [7:0] idx);
    hits = (word_index(addr) == {2'b00, idx}) && (addr[1:0] == 2'b00);
  endfunction : hits

  localparam int IRQ_W = amp_fault_pkg::IRQ_BITS;
  logic       access;
  logic       wr;
  logic       rd;
  logic       clear_cmd;
  logic [7:0] wbyte;
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_wclear;
  logic       mapped;

  // zero wait states: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign access  = apb_req.psel && apb_req.penable;
  assign wr      = access && apb_req.pwrite;
  assign rd      = access && !apb_req.pwrite;
  assign wbyte   = apb_req.pwdata[7:0];
  assign prdata  = st_r.prdata_r;
  assign pslverr = st_r.slverr_r;
  assign fault_report    = st_r.report_r;
  assign shutdown_active = st_r.off_r;
  // level interrupt: any unmasked sticky event
  assign irq = |(st_r.irq_status_r & st_r.irq_mask_r);

  assign mapped = hits(apb_req.paddr, amp_fault_pkg::IDX_CHAN_FAULT)
               || hits(apb_req.paddr, amp_fault_pkg::IDX_GLOBAL_SUPPLY)
               || hits(apb_req.paddr, amp_fault_pkg::IDX_GLOBAL_THERMAL)
               || hits(apb_req.paddr, amp_fault_pkg::IDX_TEMP_WARNING)
               || hits(apb_req.paddr, amp_fault_pkg::IDX_REPORT_MASK)
               || hits(apb_req.paddr, amp_fault_pkg::IDX_LATCH_CONTROL)
               || hits(apb_req.paddr, amp_fault_pkg::IDX_MISC_CONTROL)
               || hits(apb_req.paddr, amp_fault_pkg::IDX_FAULT_CLEAR)
               || hits(apb_req.paddr, amp_fault_pkg::IDX_IRQ_STATUS)
               || hits(apb_req.paddr, amp_fault_pkg::IDX_IRQ_MASK);

  // self-clearing pulse: never stored, so the register reads zero
  assign clear_cmd = wr && hits(apb_req.paddr, amp_fault_pkg::IDX_FAULT_CLEAR)
                     && wbyte[amp_fault_pkg::POS_CLEAR];

  assign irq_wclear = (wr && hits(apb_req.paddr, amp_fault_pkg::IDX_IRQ_STATUS))
                      ? wbyte[IRQ_W-1:0] : '0;

  // next state of the whole block
  always_comb begin
    logic       hold_clk;
    logic       hold_sd;
    logic       hold_warn;
    logic       live_clk;
    logic       any_fault;
    logic [7:0] rbyte;
    hold_clk  = 1'b0;
    hold_sd   = 1'b0;
    hold_warn = 1'b0;
    live_clk  = 1'b0;
    any_fault = 1'b0;
    rbyte     = 8'h00;
    st_nxt    = st_r;

    hold_clk  = st_r.latch_control_r[amp_fault_pkg::LAT_CLOCK];
    hold_sd   = st_r.latch_control_r[amp_fault_pkg::LAT_SHUTDOWN];
    hold_warn = st_r.latch_control_r[amp_fault_pkg::LAT_WARNING];

    // latched bits keep their value until clear; unlatched follow the cause
    // a cause still present during the clear sets the bit again at once
    st_nxt.shutdown_r = fault_in.shutdown
                        || (hold_sd && st_r.shutdown_r && !clear_cmd);
    st_nxt.warning_r  = fault_in.warning
                        || (hold_warn && st_r.warning_r && !clear_cmd);
    st_nxt.clock_r    = fault_in.clock
                        || (hold_clk && st_r.clock_r && !clear_cmd);
    // detection status either follows the detector or holds until clear
    live_clk = fault_in.clock;
    st_nxt.clk_detect_r = st_r.misc_control_r[amp_fault_pkg::MISC_CLK_HOLD]
                          ? (live_clk || (st_r.clk_detect_r && !clear_cmd))
                          : live_clk;
    // per-channel analog faults held until the clear command
    st_nxt.dc_r = fault_in.dc | (clear_cmd ? 2'b00 : st_r.dc_r);
    st_nxt.oc_r = fault_in.oc | (clear_cmd ? 2'b00 : st_r.oc_r);
    st_nxt.power_low_r  = fault_in.power_low;
    st_nxt.power_high_r = fault_in.power_high;

    // power stage off: with auto recovery it leaves when the die cools,
    // without it only the clear command brings it back
    if (fault_in.shutdown) begin
      st_nxt.off_r = 1'b1;
    end else if (st_r.misc_control_r[amp_fault_pkg::MISC_AUTO_REC] || clear_cmd) begin
      st_nxt.off_r = 1'b0;
    end

    // external report: masks gate reporting only, never the status bits
    any_fault =
        ((st_r.shutdown_r || fault_in.shutdown)
          && !st_r.report_mask_r[amp_fault_pkg::MSK_SHUTDOWN])
     || (fault_in.core_low  && !st_r.report_mask_r[amp_fault_pkg::MSK_CORE_LOW])
     || (fault_in.core_high && !st_r.report_mask_r[amp_fault_pkg::MSK_CORE_HIGH])
     || ((st_r.clock_r || fault_in.clock)
          && !st_r.report_mask_r[amp_fault_pkg::MSK_CLOCK])
     || (fault_in.power_low  && !st_r.report_mask_r[amp_fault_pkg::MSK_POWER_LOW])
     || (fault_in.power_high && !st_r.report_mask_r[amp_fault_pkg::MSK_POWER_HIGH])
     || ((|(st_r.dc_r | fault_in.dc)) && !st_r.report_mask_r[amp_fault_pkg::MSK_DC])
     || ((|(st_r.oc_r | fault_in.oc)) && !st_r.report_mask_r[amp_fault_pkg::MSK_OC])
     || ((st_r.warning_r || fault_in.warning)
          && !st_r.latch_control_r[amp_fault_pkg::LAT_WARN_MASK]);
    st_nxt.report_r = any_fault;

    // sticky interrupt events; a new event wins over a write-one clear
    irq_events[amp_fault_pkg::IRQ_SHUTDOWN] = fault_in.shutdown;
    irq_events[amp_fault_pkg::IRQ_WARNING]  = fault_in.warning;
    irq_events[amp_fault_pkg::IRQ_CLOCK]    = fault_in.clock;
    irq_events[amp_fault_pkg::IRQ_SUPPLY]   = fault_in.power_low || fault_in.power_high
                                              || fault_in.core_low || fault_in.core_high;
    irq_events[amp_fault_pkg::IRQ_CHANNEL]  = |(fault_in.dc | fault_in.oc);
    st_nxt.irq_status_r = (st_r.irq_status_r & ~irq_wclear) | irq_events;

    // register writes
    if (wr) begin
      if (hits(apb_req.paddr, amp_fault_pkg::IDX_REPORT_MASK)) begin
        st_nxt.report_mask_r = wbyte;
      end
      if (hits(apb_req.paddr, amp_fault_pkg::IDX_LATCH_CONTROL)) begin
        // reserved 1-0 stay zero; reserved 7-6 are writable
        st_nxt.latch_control_r = wbyte & amp_fault_pkg::LAT_WRITABLE;
      end
      if (hits(apb_req.paddr, amp_fault_pkg::IDX_MISC_CONTROL)) begin
        st_nxt.misc_control_r = wbyte;
      end
      if (hits(apb_req.paddr, amp_fault_pkg::IDX_IRQ_MASK)) begin
        st_nxt.irq_mask_r = wbyte[IRQ_W-1:0];
      end
    end

    // read data captured in the access cycle, valid from the next edge on
    rbyte = 8'h00;
    if (hits(apb_req.paddr, amp_fault_pkg::IDX_CHAN_FAULT)) begin
      rbyte = {4'h0, st_r.dc_r, st_r.oc_r};
    end else if (hits(apb_req.paddr, amp_fault_pkg::IDX_GLOBAL_SUPPLY)) begin
      rbyte[amp_fault_pkg::POS_CLK_FAULT] = st_r.clock_r;
      rbyte[amp_fault_pkg::POS_PVDD_OV]   = st_r.power_high_r;
      rbyte[amp_fault_pkg::POS_PVDD_UV]   = st_r.power_low_r;
    end else if (hits(apb_req.paddr, amp_fault_pkg::IDX_GLOBAL_THERMAL)) begin
      rbyte[amp_fault_pkg::POS_SHUTDOWN] = st_r.shutdown_r;
    end else if (hits(apb_req.paddr, amp_fault_pkg::IDX_TEMP_WARNING)) begin
      rbyte[amp_fault_pkg::POS_WARNING] = st_r.warning_r;
    end else if (hits(apb_req.paddr, amp_fault_pkg::IDX_REPORT_MASK)) begin
      rbyte = st_r.report_mask_r;
    end else if (hits(apb_req.paddr, amp_fault_pkg::IDX_LATCH_CONTROL)) begin
      rbyte = st_r.latch_control_r;
    end else if (hits(apb_req.paddr, amp_fault_pkg::IDX_MISC_CONTROL)) begin
      rbyte = st_r.misc_control_r;
    end else if (hits(apb_req.paddr, amp_fault_pkg::IDX_IRQ_STATUS)) begin
      rbyte = {3'b000, st_r.irq_status_r};
    end else if (hits(apb_req.paddr, amp_fault_pkg::IDX_IRQ_MASK)) begin
      rbyte = {3'b000, st_r.irq_mask_r};
    end
    if (rd) begin
      st_nxt.prdata_r = {24'h000000, rbyte};
    end
    st_nxt.slverr_r = access && !mapped;
  end

  // one register for the whole state
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_r                 <= '0;
      st_r.report_mask_r   <= amp_fault_pkg::RST_REPORT_MASK;
      st_r.latch_control_r <= amp_fault_pkg::RST_LATCH_CONTROL;
      st_r.misc_control_r  <= amp_fault_pkg::RST_MISC_CONTROL;
      st_r.irq_mask_r      <= amp_fault_pkg::RST_IRQ_MASK[IRQ_W-1:0];
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : amp_fault_report_regs

// ==== test/amp_fault_report_regs_asserts.sv ====
// checker: port-level properties of the fault report register block
`timescale 1ns/10ps
module amp_fault_report_regs_asserts (
  input wire logic                     core_clk,
  input wire logic                     rstn,
  input wire amp_fault_pkg::apb_req_t  apb_req,
  input wire logic                     pready,
  input wire logic [31:0]              prdata,
  input wire logic                     pslverr,
  input wire amp_fault_pkg::fault_in_t fault_in,
  input wire logic                     fault_report,
  input wire logic                     shutdown_active,
  input wire logic                     irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic        rd;
  logic        cause;
  logic [11:0] a;
  // read data is registered at the access edge, so it is judged one cycle later
  assign rd = apb_req.psel && apb_req.penable && !apb_req.pwrite && pready;
  assign a = apb_req.paddr;
  // a report can only start after a live cause or a register write (unmask)
  assign cause = (fault_in != '0) || (apb_req.psel && apb_req.pwrite);
  AST_UPPER_ZERO: assert property (rd |=> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_THERM_RSVD: assert property (rd && a == 12'h1c8 |=> prdata[7:1] == 7'h0)
    else $error("thermal status reserved bits set");
  AST_WARN_RSVD: assert property (rd && a == 12'h1cc |=> {prdata[7:3], prdata[1:0]} == 7'h0)
    else $error("warning status reserved bits set");
  AST_CLEAR_READ: assert property (rd && a == 12'h1e0 |=> prdata[7:0] == 8'h00)
    else $error("fault clear register did not read zero");
  AST_SHUT_RISE: assert property ($rose(fault_in.shutdown) |-> ##[1:2] shutdown_active)
    else $error("shutdown not entered after cause");
  AST_SHUT_HOLD: assert property (shutdown_active && fault_in.shutdown |=> shutdown_active)
    else $error("shutdown left while cause present");
  AST_SHUT_ENTER: assert property ($rose(shutdown_active) |->
    $past(fault_in.shutdown) || $past(fault_in.shutdown, 2))
    else $error("shutdown entered without cause");
  AST_REPORT_CAUSE: assert property ($rose(fault_report) |-> $past(cause) || $past(cause, 2))
    else $error("fault report raised without cause");
  COV_ERR: cover property (rd ##1 pslverr);
  COV_SHUT: cover property ($rose(shutdown_active) ##[1:20] !shutdown_active);
  COV_IRQ: cover property ($rose(irq));
endmodule : amp_fault_report_regs_asserts

bind amp_fault_report_regs amp_fault_report_regs_asserts u_chk (
  .core_clk(core_clk), .rstn(rstn), .apb_req(apb_req), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .fault_in(fault_in), .fault_report(fault_report),
  .shutdown_active(shutdown_active), .irq(irq));

// ==== test/amp_fault_report_regs_tb.sv ====
// testbench: register map, masking, latching, clear and interrupt of the fault report block
`timescale 1ns/10ps
module amp_fault_report_regs_tb;
  typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic                     core_clk = 1'b0;
  logic                     rstn     = 1'b0;
  amp_fault_pkg::apb_req_t  apb_req  = '0;
  amp_fault_pkg::fault_in_t fault_in = '0;
  logic                     pready, pslverr, fault_report, shutdown_active, irq, err;
  logic [31:0]              prdata;
  logic [7:0]               rd;
  int                       bad_count = 0;
  int                       samples_checked = 0;
  // fault cause for each report mask bit, bit 0 first
  localparam logic [10:0] FMAP [8] = '{11'h001, 11'h004, 11'h010, 11'h020,
                                       11'h100, 11'h040, 11'h080, 11'h400};
  // reset values first ..then write and read back
  row_t rows [15] = '{'{0, 12'h1d0, 0, 8'h00}, '{0, 12'h1d4, 0, 8'hf8}, '{0, 12'h1d8, 0, 8'h00},
    '{0, 12'h1c8, 0, 8'h00}, '{0, 12'h1cc, 0, 8'h00}, '{0, 12'h1e0, 0, 8'h00},
    '{1, 12'h1d0, 8'hff, 8'hff}, '{1, 12'h1d0, 8'h00, 8'h00}, '{1, 12'h1d4, 8'hff, 8'hfc},
    '{1, 12'h1d4, 8'hf8, 8'hf8}, '{1, 12'h1d8, 8'h90, 8'h90}, '{1, 12'h1d8, 8'h00, 8'h00},
    '{1, 12'h1f4, 8'h1f, 8'h1f}, '{1, 12'h1f4, 8'h00, 8'h00}, '{1, 12'h1e0, 8'h80, 8'h00}};

  amp_fault_report_regs dut (.core_clk(core_clk), .rstn(rstn), .apb_req(apb_req),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .fault_in(fault_in),
    .fault_report(fault_report), .shutdown_active(shutdown_active), .irq(irq));

  always #20 core_clk = ~core_clk;

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask : chk1

  // one apb transfer; data and error are registered, so they are taken just after the edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: {24'h0, d}};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      summarize();
    end else begin
      apb_req <= '0;
      #1;
      rd = prdata[7:0];
      err = pslverr;
    end
  endtask : apb

  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk8(rd, e);
  endtask : rchk

  task automatic drv(input logic [10:0] v, input int k);
    @(posedge core_clk);
    fault_in <= amp_fault_pkg::fault_in_t'(v);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : drv

  initial begin
    #1 chk8({5'h0, fault_report, shutdown_active, irq}, 8'h00);
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) apb(1'b1, rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
    end
    $display("end register table");
    // each mask bit hides its own fault, which reports once unmasked; removing the cause and a clear then release the report
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 12'h1d0, 8'h01 << i);
      drv(FMAP[i], 3);
      chk1(fault_report, 1'b0);
      apb(1'b1, 12'h1d0, 8'h00);
      drv(FMAP[i], 3);
      chk1(fault_report, 1'b1);
      drv(11'h000, 1);
      apb(1'b1, 12'h1e0, 8'h80);
      drv(11'h000, 3);
      chk1(fault_report, 1'b0);
    end
    $display("end mask sweep");
    drv(11'h009, 2);
    drv(11'h000, 2);
    rchk(12'h1c0, 8'h09);
    apb(1'b1, 12'h1f0, 8'h1f);
    drv(11'h400, 2);
    drv(11'h000, 3);
    rchk(12'h1c8, 8'h01);
    chk1(shutdown_active, 1'b1);
    rchk(12'h1f0, 8'h01);
    chk1(irq, 1'b0);
    apb(1'b1, 12'h1f4, 8'h01);
    chk1(irq, 1'b1);
    apb(1'b1, 12'h1f4, 8'h00);
    chk1(irq, 1'b0);
    apb(1'b1, 12'h1f4, 8'h01);
    apb(1'b1, 12'h1f0, 8'h01);
    chk1(irq, 1'b0);
    apb(1'b1, 12'h1e0, 8'h80);
    rchk(12'h1c8, 8'h00);
    rchk(12'h1c0, 8'h00);
    chk1(shutdown_active, 1'b0);
    $display("end shutdown and interrupt");
    apb(1'b1, 12'h1d8, 8'h10);
    drv(11'h400, 3);
    chk1(shutdown_active, 1'b1);
    drv(11'h000, 3);
    chk1(shutdown_active, 1'b0);
    apb(1'b1, 12'h1d8, 8'h00);
    drv(11'h200, 2);
    drv(11'h000, 2);
    rchk(12'h1cc, 8'h04);
    drv(11'h100, 2);
    drv(11'h000, 3);
    chk1(fault_report, 1'b1);
    apb(1'b1, 12'h1d4, 8'hd4);
    apb(1'b1, 12'h1e0, 8'h80);
    drv(11'h200, 3);
    chk1(fault_report, 1'b0);
    rchk(12'h1cc, 8'h04);
    drv(11'h000, 3);
    rchk(12'h1cc, 8'h00);
    $display("end recovery and warning");
    apb(1'b1, 12'h000, 8'hff);
    chk1(err, 1'b1);
    rchk(12'h1d1, 8'h00);
    chk1(err, 1'b1);
    apb(1'b1, 12'h1d0, 8'hff);
    @(posedge core_clk);
    rstn <= 1'b0;
    @(posedge core_clk);
    rstn <= 1'b1;
    rchk(12'h1d0, 8'h00);
    rchk(12'h1d4, 8'hf8);
    $display("end refusal and reset");
    summarize();
  end
endmodule : amp_fault_report_regs_tb
